// File: ida_pkg.sv
// Package with offsets, widths, reset values and access kinds of the indirect addressing unit.
package ida_pkg;
	localparam int IDA_DW = 8;
	localparam int IDA_AW = 8;
	localparam int IDA_MW = 12;
	localparam int IDA_HIW = 4;
	// Register offsets; each pointer owns seven of the eight locations in its block, the eighth holds bank or working register.
	localparam logic [7:0] IDA_PTR1_BASE = 8'h00;
	localparam logic [7:0] IDA_PTR2_BASE = 8'h08;
	localparam logic [7:0] IDA_OFS_PLAIN = 8'h00;
	localparam logic [7:0] IDA_OFS_POSTINC = 8'h01;
	localparam logic [7:0] IDA_OFS_POSTDEC = 8'h02;
	localparam logic [7:0] IDA_OFS_PREINC = 8'h03;
	localparam logic [7:0] IDA_OFS_PLUSW = 8'h04;
	localparam logic [7:0] IDA_OFS_HIGH = 8'h05;
	localparam logic [7:0] IDA_OFS_LOW = 8'h06;
	localparam logic [7:0] IDA_ADDR_BANK = 8'h07;
	localparam logic [7:0] IDA_ADDR_WORKING_ACCUMULATOR = 8'h0F;
	// Reset values, unmapped read value and pointer step.
	localparam logic [3:0] IDA_RST_PTR_HI = 4'h0;
	localparam logic [7:0] IDA_RST_PTR_LO = 8'h00;
	localparam logic [3:0] IDA_RST_BANK = 4'h0;
	localparam logic [7:0] IDA_RST_WORKING_ACCUMULATOR = 8'h00;
	localparam logic [7:0] IDA_RST_RDATA = 8'h00;
	localparam logic [7:0] IDA_RD_UNMAPPED = 8'h00;
	localparam logic [11:0] IDA_PTR_STEP = 12'h001;
	typedef enum logic [2:0] {
		IDA_K_NONE,
		IDA_K_PLAIN,
		IDA_K_POSTINC,
		IDA_K_POSTDEC,
		IDA_K_PREINC,
		IDA_K_PLUSW
	} ida_kind_t;
endpackage

// File: ida_pointer.sv
// One indirect pointer: high and low part, effective address and pointer update.
module ida_pointer import ida_pkg::*; (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Control from the register decode.
	input wire logic i_hi_we,
	input wire logic i_lo_we,
	input wire logic [7:0] i_wdata,
	input wire ida_kind_t i_kind,
	input wire logic [7:0] i_working_accumulator,
	// Pointer value and effective address.
	output logic [11:0] o_ptr,
	output logic [11:0] o_addr
);
	typedef struct packed {
		logic [3:0] hi;
		logic [7:0] lo;
	} ida_ptr_state_t;

	ida_ptr_state_t s_q;
	ida_ptr_state_t s_d;
	logic [11:0] cur;
	logic [11:0] nxt;

	always_comb begin
		s_d = s_q;
		cur = {s_q.hi, s_q.lo};
		nxt = cur;
		o_addr = cur;
		case (i_kind)
			IDA_K_POSTINC: nxt = cur + IDA_PTR_STEP;
			IDA_K_POSTDEC: nxt = cur - IDA_PTR_STEP;
			IDA_K_PREINC: begin
				nxt = cur + IDA_PTR_STEP;
				o_addr = nxt;
			end
			IDA_K_PLUSW: o_addr = cur + {4'h0, i_working_accumulator};
			default: nxt = cur;
		endcase
		{s_d.hi, s_d.lo} = nxt;
		if (i_hi_we) begin
			s_d.hi = i_wdata[3:0];
		end
		if (i_lo_we) begin
			s_d.lo = i_wdata;
		end
	end

	// The low byte is architecturally undefined after reset; it is cleared only to stay deterministic.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= {IDA_RST_PTR_HI, IDA_RST_PTR_LO};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_ptr = {s_q.hi, s_q.lo};
endmodule

// File: ida_unit.sv
// Indirect data addressing unit with two pointers, bank select and working register.
// Summary of operation
// - Post-decrement access uses pointer, then decrements.
// - Pre-increment access increments pointer, then accesses.
// - Offset access adds working register, pointer unchanged.
// - Pointer high part is four bits, resets zero.
// - Pointer low byte eight bits, reset value undefined; the unit clears it to 00 at reset.
//
// The placing of the registers and strobed register access were decided locally.
module ida_unit import ida_pkg::*; (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port.
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [7:0] o_rdata,
	// Data memory port, combinational read.
	output logic [11:0] o_mem_addr,
	output logic o_mem_we,
	output logic o_mem_re,
	output logic [7:0] o_mem_wdata,
	input wire logic [7:0] i_mem_rdata,
	// Core-side views.
	output logic [3:0] o_bank_selector,
	output logic [7:0] o_working_accumulator
);
	typedef struct packed {
		logic [7:0] rdata;
		logic [3:0] bank;
		logic [7:0] working_accumulator;
	} ida_state_t;

	ida_state_t s_q;
	ida_state_t s_d;
	ida_kind_t kind_w [2];
	logic hi_we_w [2];
	logic lo_we_w [2];
	logic [11:0] ptr_w [2];
	logic [11:0] addr_w [2];
	logic virt_any;

	for (genvar g = 0; g < 2; g++) begin : g_ptr
		localparam logic [7:0] BASE = (g == 0) ? IDA_PTR1_BASE : IDA_PTR2_BASE;

		always_comb begin
			kind_w[g] = IDA_K_NONE;
			if (i_we || i_re) begin
				if (i_addr == BASE + IDA_OFS_PLAIN) begin
					kind_w[g] = IDA_K_PLAIN;
				end else if (i_addr == BASE + IDA_OFS_POSTINC) begin
					kind_w[g] = IDA_K_POSTINC;
				end else if (i_addr == BASE + IDA_OFS_POSTDEC) begin
					kind_w[g] = IDA_K_POSTDEC;
				end else if (i_addr == BASE + IDA_OFS_PREINC) begin
					kind_w[g] = IDA_K_PREINC;
				end else if (i_addr == BASE + IDA_OFS_PLUSW) begin
					kind_w[g] = IDA_K_PLUSW;
				end
			end
			hi_we_w[g] = i_we && (i_addr == BASE + IDA_OFS_HIGH);
			lo_we_w[g] = i_we && (i_addr == BASE + IDA_OFS_LOW);
		end

		ida_pointer u_ptr (
			.i_clk(i_clk),
			.i_rst(i_rst),
			.i_hi_we(hi_we_w[g]),
			.i_lo_we(lo_we_w[g]),
			.i_wdata(i_wdata),
			.i_kind(kind_w[g]),
			.i_working_accumulator(s_q.working_accumulator),
			.o_ptr(ptr_w[g]),
			.o_addr(addr_w[g])
		);
	end

	assign virt_any = (kind_w[0] != IDA_K_NONE) || (kind_w[1] != IDA_K_NONE);
	assign o_mem_addr = (kind_w[1] != IDA_K_NONE) ? addr_w[1] : addr_w[0];
	assign o_mem_we = i_we && virt_any;
	assign o_mem_re = i_re && virt_any;
	assign o_mem_wdata = i_wdata;

	always_comb begin
		s_d = s_q;
		if (i_we) begin
			if (i_addr == IDA_ADDR_BANK) begin
				s_d.bank = i_wdata[3:0];
			end else if (i_addr == IDA_ADDR_WORKING_ACCUMULATOR) begin
				s_d.working_accumulator = i_wdata;
			end
		end
		if (i_re) begin
			if (virt_any) begin
				s_d.rdata = i_mem_rdata;
			end else if (i_addr == IDA_PTR1_BASE + IDA_OFS_HIGH) begin
				s_d.rdata = {4'h0, ptr_w[0][11:8]};
			end else if (i_addr == IDA_PTR1_BASE + IDA_OFS_LOW) begin
				s_d.rdata = ptr_w[0][7:0];
			end else if (i_addr == IDA_PTR2_BASE + IDA_OFS_HIGH) begin
				s_d.rdata = {4'h0, ptr_w[1][11:8]};
			end else if (i_addr == IDA_PTR2_BASE + IDA_OFS_LOW) begin
				s_d.rdata = ptr_w[1][7:0];
			end else if (i_addr == IDA_ADDR_BANK) begin
				s_d.rdata = {4'h0, s_q.bank};
			end else if (i_addr == IDA_ADDR_WORKING_ACCUMULATOR) begin
				s_d.rdata = s_q.working_accumulator;
			end else begin
				s_d.rdata = IDA_RD_UNMAPPED;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= {IDA_RST_RDATA, IDA_RST_BANK, IDA_RST_WORKING_ACCUMULATOR};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_rdata = s_q.rdata;
	assign o_bank_selector = s_q.bank;
	assign o_working_accumulator = s_q.working_accumulator;

	// Checks on pointer two.
	sequence ida_s_wr_lo2;
		i_we && (i_addr == IDA_PTR2_BASE + IDA_OFS_LOW);
	endsequence

	sequence ida_s_rd_lo2;
		i_re && (i_addr == IDA_PTR2_BASE + IDA_OFS_LOW);
	endsequence

	sequence ida_s_ptr2_increment_then_access;
		kind_w[1] == IDA_K_PREINC;
	endsequence

	a_ptr2_postdec_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(kind_w[1] == IDA_K_POSTDEC) |-> (o_mem_addr == ptr_w[1])
			##1 (ptr_w[1] == $past(ptr_w[1]) - IDA_PTR_STEP))
		else $error("post-decrement of pointer two wrong");

	a_ptr2_preinc_step: assert property (@(posedge i_clk) disable iff (i_rst)
		ida_s_ptr2_increment_then_access |-> (o_mem_addr == ptr_w[1] + IDA_PTR_STEP) ##1 (ptr_w[1] == $past(o_mem_addr)))
		else $error("pre-increment of pointer two wrong");

	a_ptr2_offset_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(kind_w[1] == IDA_K_PLUSW) |-> (o_mem_addr == ptr_w[1] + {4'h0, s_q.working_accumulator}) ##1 $stable(ptr_w[1]))
		else $error("offset access of pointer two wrong");

	a_ptr2_high_reset: assert property (@(posedge i_clk) disable iff (i_rst)
		$past(i_rst) |-> (ptr_w[1][11:8] == IDA_RST_PTR_HI))
		else $error("pointer two high part not zero after reset");

	a_ptr2_high_width: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_re && (i_addr == IDA_PTR2_BASE + IDA_OFS_HIGH)) |=> (o_rdata == {4'h0, $past(ptr_w[1][11:8])}))
		else $error("pointer two high part reads upper bits");

	a_ptr2_low_store: assert property (@(posedge i_clk) disable iff (i_rst)
		ida_s_wr_lo2 ##1 ida_s_rd_lo2 |=> (o_rdata == $past(i_wdata, 2)))
		else $error("pointer two low byte not stored");

	a_ptr2_plain_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		(kind_w[1] == IDA_K_PLAIN) |-> (o_mem_addr == ptr_w[1]) ##1 $stable(ptr_w[1]))
		else $error("plain access changed pointer two");

	a_ptr2_postinc_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(kind_w[1] == IDA_K_POSTINC) |-> (o_mem_addr == ptr_w[1])
			##1 (ptr_w[1] == $past(ptr_w[1]) + IDA_PTR_STEP))
		else $error("post-increment of pointer two wrong");
endmodule

// File: indirect_data_addressing_tb.sv
// Self-checking testbench of the indirect data addressing unit.
module indirect_data_addressing_tb import ida_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_rst, i_we, i_re;
	logic [7:0] i_addr, i_wdata, i_mem_rdata, o_rdata, o_mem_wdata, o_working_accumulator;
	logic [11:0] o_mem_addr;
	logic o_mem_we, o_mem_re;
	logic rd_pend = 1'b0;
	logic [7:0] rd_a = 8'h00;
	logic [11:0] ev;
	logic [3:0] o_bank_selector;
	logic [7:0] mem [4096];
	logic [7:0] em [4096];
	logic [11:0] p [2];
	logic [7:0] w, ks [5];
	logic [7:0] rq [$];
	logic [11:0] aq [$];
	int fail_count, check_count;
	ida_unit DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re),
		.o_rdata(o_rdata), .o_mem_addr(o_mem_addr), .o_mem_we(o_mem_we), .o_mem_re(o_mem_re),
		.o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .o_bank_selector(o_bank_selector),
		.o_working_accumulator(o_working_accumulator));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// Data memory seen by the unit: combinational read, write on the clock.
	always_comb i_mem_rdata = mem[o_mem_addr];
	always @(posedge i_clk) begin
		if (o_mem_we === 1'b1) mem[o_mem_addr] <= o_mem_wdata;
	end
	task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	// Watches outputs where settled and compares against the oldest note.
	always @(negedge i_clk) begin
		if (rd_pend === 1'b1) begin
			ev = (rq.size() > 0) ? {4'h0, rq.pop_front()} : 12'hFFF;
			chk("rdata", {4'h0, o_rdata}, ev);
			if (rd_a == IDA_ADDR_BANK) chk("bank_selector", {8'h00, o_bank_selector}, ev);
			if (rd_a == IDA_ADDR_WORKING_ACCUMULATOR) chk("working_accumulator", {4'h0, o_working_accumulator}, ev);
		end
		if (o_mem_re === 1'b1 || o_mem_we === 1'b1) begin
			chk("mem_note", {11'h000, aq.size() > 0}, 12'h001);
			if (aq.size() > 0) chk("mem_addr", o_mem_addr, aq.pop_front());
		end
		rd_pend = i_re;
		rd_a = i_addr;
	end
	task automatic final_report();
		if (rq.size() + aq.size() > 0) fail_count++;
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic we, input logic re, input logic [7:0] a, input logic [7:0] d);
		i_we <= we;
		i_re <= re;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_we <= 1'b0;
		i_re <= 1'b0;
		@(posedge i_clk);
	endtask
	// Write then read of one register with no idle cycle between the two strobes.
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		rq.push_back(d);
		i_we <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_we <= 1'b0;
		i_re <= 1'b1;
		@(posedge i_clk);
		i_re <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic setp(input int n, input logic [11:0] v);
		bus(1'b1, 1'b0, (n ? IDA_PTR2_BASE : IDA_PTR1_BASE) | IDA_OFS_HIGH, {4'h0, v[11:8]});
		bus(1'b1, 1'b0, (n ? IDA_PTR2_BASE : IDA_PTR1_BASE) | IDA_OFS_LOW, v[7:0]);
		p[n] = v;
	endtask
	task automatic chkp(input int n);
		rd((n ? IDA_PTR2_BASE : IDA_PTR1_BASE) | IDA_OFS_HIGH, {4'h0, p[n][11:8]});
		rd((n ? IDA_PTR2_BASE : IDA_PTR1_BASE) | IDA_OFS_LOW, p[n][7:0]);
	endtask
	// Works out the effective address and pointer update from the access kind.
	task automatic acc(input int n, input logic [7:0] ofs, input logic wrt, input logic [7:0] d);
		logic [11:0] a;
		if (ofs == IDA_OFS_PREINC) p[n] = p[n] + 12'h001;
		a = (ofs == IDA_OFS_PLUSW) ? p[n] + {4'h0, w} : p[n];
		if (ofs == IDA_OFS_POSTINC) p[n] = p[n] + 12'h001;
		if (ofs == IDA_OFS_POSTDEC) p[n] = p[n] - 12'h001;
		aq.push_back(a);
		if (wrt) em[a] = d;
		else rq.push_back(em[a]);
		bus(wrt, !wrt, (n ? IDA_PTR2_BASE : IDA_PTR1_BASE) | ofs, d);
	endtask
	initial begin
		#100000;
		fail_count++;
		final_report();
	end
	initial begin
		{i_we, i_re, i_addr, i_wdata} = '0;
		i_rst = 1'b1;
		ks = '{IDA_OFS_PLAIN, IDA_OFS_POSTINC, IDA_OFS_POSTDEC, IDA_OFS_PREINC, IDA_OFS_PLUSW};
		void'($urandom(43));
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'($urandom);
			em[i] = mem[i];
		end
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd(IDA_PTR2_BASE | IDA_OFS_HIGH, 8'h00);
		rd(IDA_PTR1_BASE | IDA_OFS_HIGH, 8'h00);
		rd(IDA_ADDR_BANK, 8'h00);
		rd(IDA_ADDR_WORKING_ACCUMULATOR, IDA_RST_WORKING_ACCUMULATOR);
		$display("test reset done");
		bus(1'b1, 1'b0, IDA_PTR2_BASE | IDA_OFS_HIGH, 8'hFF);
		rd(IDA_PTR2_BASE | IDA_OFS_HIGH, 8'h0F);
		bus(1'b1, 1'b0, IDA_PTR2_BASE | IDA_OFS_LOW, 8'hFF);
		rd(IDA_PTR2_BASE | IDA_OFS_LOW, 8'hFF);
		wr_rd(IDA_PTR2_BASE | IDA_OFS_LOW, 8'($urandom));
		bus(1'b1, 1'b0, IDA_ADDR_BANK, 8'hFF);
		rd(IDA_ADDR_BANK, 8'h0F);
		$display("test fields done");
		for (int r = 0; r < 3; r++) begin
			w = (r == 2) ? 8'hFF : 8'($urandom);
			bus(1'b1, 1'b0, IDA_ADDR_WORKING_ACCUMULATOR, w);
			for (int n = 0; n < 2; n++) begin
				setp(n, (r == 0) ? 12'h000 : ((r == 1) ? 12'hFFF : 12'($urandom)));
				for (int k = 0; k < 10; k++) begin
					acc(n, ks[k / 2], k[0], 8'($urandom));
					chkp(n);
				end
			end
		end
		$display("test access kinds done");
		bus(1'b1, 1'b0, 8'h10, 8'h55);
		rd(8'h10, IDA_RD_UNMAPPED);
		rd(IDA_ADDR_WORKING_ACCUMULATOR, w);
		$display("test unmapped done");
		repeat (3) @(posedge i_clk);
		final_report();
	end
endmodule
